/* File: redriver_cfg_map.svh */
// offsets, field positions, reset values and timing values (MHz, us, ns) of the config block
`ifndef REDRIVER_CFG_MAP_SVH
`define REDRIVER_CFG_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_STATUS    8'h00
`define REG_DET_TRIG  8'h04
`define REG_BANK_ADDR 8'h08
`define REG_CH_CFG    8'h10
// ----------------------------------------
// channel config fields and reset
// ----------------------------------------
`define CFG_S1_LSB    0
`define CFG_S2_LSB    4
`define CFG_PROF_LSB  7
`define CFG_SKIP_BIT  11
`define CFG_FLAT_LSB  12
`define CFG_RESET     15'h5000
// ----------------------------------------
// strap levels and addresses
// ----------------------------------------
`define LVL_0         3'h0
`define LVL_1         3'h1
`define LVL_2         3'h2
`define LVL_3         3'h3
`define LVL_FLOAT     3'h4
`define ADDR_BASE_L1  7'h18
`define ADDR_BASE_L2  7'h20
`define ADDR_NONE     7'h00
`define AXI_OKAY      2'h0
`define AXI_SLVERR    2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_FREQ_MHZ  250
`define POLL_TIME_US  150
`define PIN_HOLD_US   200
`define SENSE_TIME_NS 40
`endif

/* File: redriver_cfg_pkg.sv */
// types shared by the redriver configuration block
package redriver_cfg_pkg;
  typedef logic [2:0]  lvl_t;
  typedef logic [14:0] ch_cfg_t;
  typedef enum logic [2:0] {
    DET_IDLE,
    DET_PROBE,
    DET_SENSE,
    DET_WAIT,
    DET_FOUND
  } det_state_e;
endpackage

/* File: redriver_config_rx_detect.sv */
// strap decode, equalizer setting mux, far-end detect and register slave
`timescale 1ns/1ps
`include "redriver_cfg_map.svh"
module redriver_config_rx_detect #(
  parameter int unsigned POLL_CYCLES = `POLL_TIME_US * `CLK_FREQ_MHZ,
  parameter int unsigned HOLD_CYCLES = `PIN_HOLD_US * `CLK_FREQ_MHZ
) (
  input  logic                    mclk_i,
  input  logic                    nrst_i,
  input  redriver_cfg_pkg::lvl_t  boost_select_high_pin_i,
  input  redriver_cfg_pkg::lvl_t  boost_select_low_pin_i,
  input  redriver_cfg_pkg::lvl_t  gain_pin_i,
  input  redriver_cfg_pkg::lvl_t  mode_pin_i,
  input  redriver_cfg_pkg::lvl_t  rxdet_pin_i,
  input  redriver_cfg_pkg::lvl_t  addr_pin_i,
  input  logic                    powerdown_pin_i,
  input  logic                    select_pin_i,
  input  logic [3:0]              far_end_present_i,
  input  logic [7:0]              s_axi_awaddr,
  input  logic                    s_axi_awvalid,
  output logic                    s_axi_awready,
  input  logic [31:0]             s_axi_wdata,
  input  logic [3:0]              s_axi_wstrb,
  input  logic                    s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  logic                    s_axi_bready,
  input  logic [7:0]              s_axi_araddr,
  input  logic                    s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  logic                    s_axi_rready,
  output logic [15:0]             first_stage_boost_code_o,
  output logic [11:0]             second_stage_boost_code_o,
  output logic [15:0]             midband_shape_code_o,
  output logic [3:0]              first_stage_skip_o,
  output logic [11:0]             flat_gain_code_o,
  output logic [3:0]              probe_o,
  output logic [3:0]              term_50_o,
  output logic                    standby_o,
  output logic                    reg_mode_o,
  output logic [6:0]              bank0_addr_o,
  output logic [6:0]              bank1_addr_o
);
  import redriver_cfg_pkg::*;

  localparam int unsigned SENSE_CYCLES = (`SENSE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000;

  // ----------------------------------------
  // level decode and equalizer table
  // ----------------------------------------
  function automatic lvl_t lvl(input lvl_t code);
    lvl = (code > `LVL_FLOAT) ? `LVL_FLOAT : code;
  endfunction

  function automatic logic [2:0] flat_map(input lvl_t l);
    unique case (l)
      `LVL_0:  flat_map = 3'h0;
      `LVL_1:  flat_map = 3'h1;
      `LVL_2:  flat_map = 3'h3;
      `LVL_3:  flat_map = 3'h7;
      default: flat_map = 3'h5;
    endcase
  endfunction

  // {skip, shape, stage two, stage one}
  function automatic logic [11:0] eq_row(input logic [4:0] idx);
    unique case (idx)
      5'h00:   eq_row = {1'b1, 4'h0, 3'h0, 4'h0};
      5'h01:   eq_row = {1'b1, 4'h0, 3'h0, 4'h1};
      5'h02:   eq_row = {1'b1, 4'h0, 3'h0, 4'h3};
      5'h03:   eq_row = {1'b1, 4'h0, 3'h0, 4'h7};
      5'h04:   eq_row = {1'b1, 4'h0, 3'h1, 4'h7};
      5'h05:   eq_row = {1'b0, 4'h1, 3'h0, 4'h0};
      5'h06:   eq_row = {1'b0, 4'h1, 3'h0, 4'h1};
      5'h07:   eq_row = {1'b0, 4'h1, 3'h0, 4'h2};
      5'h08:   eq_row = {1'b0, 4'h3, 3'h0, 4'h3};
      5'h09:   eq_row = {1'b0, 4'h3, 3'h0, 4'h4};
      5'h0a:   eq_row = {1'b0, 4'h7, 3'h1, 4'h5};
      5'h0b:   eq_row = {1'b0, 4'h7, 3'h1, 4'h6};
      5'h0c:   eq_row = {1'b0, 4'h7, 3'h1, 4'h8};
      5'h0d:   eq_row = {1'b0, 4'h7, 3'h1, 4'ha};
      5'h0e:   eq_row = {1'b0, 4'hf, 3'h2, 4'ha};
      5'h0f:   eq_row = {1'b0, 4'hf, 3'h3, 4'hb};
      5'h10:   eq_row = {1'b0, 4'hf, 3'h4, 4'hc};
      5'h11:   eq_row = {1'b0, 4'hf, 3'h5, 4'hd};
      5'h12:   eq_row = {1'b0, 4'hf, 3'h6, 4'he};
      default: eq_row = {1'b0, 4'hf, 3'h7, 4'hf};
    endcase
  endfunction

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic [1:0]  rst_sync_ff;
  logic        rst_n;
  logic [17:0] lvl_s1_ff, lvl_s2_ff;
  logic [5:0]  pin_s1_ff, pin_s2_ff;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // multi-bit level codes are quasi-static; only the mode decode re-reads a torn sample next cycle, the other straps keep their one capture
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      lvl_s1_ff <= 18'h0;
      lvl_s2_ff <= 18'h0;
      pin_s1_ff <= 6'h0;
      pin_s2_ff <= 6'h0;
    end else begin
      lvl_s1_ff <= {addr_pin_i, rxdet_pin_i, mode_pin_i, gain_pin_i,
                    boost_select_high_pin_i, boost_select_low_pin_i};
      lvl_s2_ff <= lvl_s1_ff;
      pin_s1_ff <= {far_end_present_i, select_pin_i, powerdown_pin_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  logic [1:0] settle_ff;
  logic       strap_done_ff, reg_mode_ff;
  lvl_t       hi_ff, lo_ff, gain_ff, rxdet_ff, addr_ff, mode_ff;
  logic [4:0] eq_idx;
  logic       det_en;
  logic [1:0] need_m1;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff     <= 2'h0;
      strap_done_ff <= 1'b0;
      hi_ff         <= `LVL_0;
      lo_ff         <= `LVL_0;
      gain_ff       <= `LVL_FLOAT;
      rxdet_ff      <= `LVL_FLOAT;
      addr_ff       <= `LVL_0;
    end else if (!strap_done_ff) begin
      settle_ff <= settle_ff + 2'h1;
      if (settle_ff == 2'h3) begin
        strap_done_ff <= 1'b1;
        hi_ff    <= (lvl(lvl_s2_ff[5:3]) > `LVL_3) ? `LVL_3 :
                    lvl(lvl_s2_ff[5:3]);
        lo_ff    <= lvl(lvl_s2_ff[2:0]);
        gain_ff  <= lvl(lvl_s2_ff[8:6]);
        rxdet_ff <= lvl(lvl_s2_ff[14:12]);
        addr_ff  <= lvl(lvl_s2_ff[17:15]);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff     <= `LVL_0;
      reg_mode_ff <= 1'b0;
    end else begin
      mode_ff     <= lvl(lvl_s2_ff[11:9]);
      reg_mode_ff <= (lvl(lvl_s2_ff[11:9]) == `LVL_2);
    end
  end

  assign eq_idx  = 5'(hi_ff * 5 + lo_ff);
  assign det_en  = (rxdet_ff != `LVL_0);
  assign need_m1 = (rxdet_ff == `LVL_1) ? 2'h2 :
                   (rxdet_ff == `LVL_2) ? 2'h1 : 2'h0;

  // ----------------------------------------
  // power-down and select event filters
  // ----------------------------------------
  logic [15:0] pd_cnt_ff, sel_cnt_ff;
  logic        pd_flt_ff, sel_flt_ff, pd_fall_ff, sel_evt_ff, pwrup_ff, pwrup_done_ff;
  logic        trig_all_ff;
  logic [3:0]  trig_reg_ff, start_ch;

  // a level counts only after it held for the full window
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt_ff  <= 16'h0;
      pd_flt_ff  <= 1'b0;
      pd_fall_ff <= 1'b0;
    end else begin
      pd_fall_ff <= 1'b0;
      if (pin_s2_ff[0] == pd_flt_ff) pd_cnt_ff <= 16'h0;
      else if (pd_cnt_ff == 16'(HOLD_CYCLES - 1)) begin
        pd_flt_ff  <= pin_s2_ff[0];
        pd_fall_ff <= pd_flt_ff;
        pd_cnt_ff  <= 16'h0;
      end else pd_cnt_ff <= pd_cnt_ff + 16'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_cnt_ff <= 16'h0;
      sel_flt_ff <= 1'b0;
      sel_evt_ff <= 1'b0;
    end else begin
      sel_evt_ff <= 1'b0;
      if (pin_s2_ff[1] == sel_flt_ff) sel_cnt_ff <= 16'h0;
      else if (sel_cnt_ff == 16'(HOLD_CYCLES - 1)) begin
        sel_flt_ff <= pin_s2_ff[1];
        sel_evt_ff <= 1'b1;
        sel_cnt_ff <= 16'h0;
      end else sel_cnt_ff <= sel_cnt_ff + 16'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwrup_ff      <= 1'b0;
      pwrup_done_ff <= 1'b0;
      trig_all_ff   <= 1'b0;
    end else begin
      pwrup_ff      <= strap_done_ff && !pwrup_done_ff && !pd_flt_ff;
      pwrup_done_ff <= pwrup_done_ff || (strap_done_ff && !pd_flt_ff);
      trig_all_ff   <= pwrup_ff || pd_fall_ff || sel_evt_ff;
    end
  end

  assign start_ch = {4{trig_all_ff}} | trig_reg_ff;

  // ----------------------------------------
  // per-channel detect machine and setting mux
  // ----------------------------------------
  ch_cfg_t    ch_cfg_ff [4];
  ch_cfg_t    strap_cfg;
  logic [3:0] far_s2;

  assign far_s2    = pin_s2_ff[5:2];
  assign strap_cfg = {flat_map(gain_ff), eq_row(eq_idx)};

  for (genvar i = 0; i < 4; i++) begin : g_ch
    det_state_e state_ff;
    logic [16:0] cnt_ff;
    logic [1:0]  hits_ff;
    logic        probe_ff, term_ff;
    ch_cfg_t     out_ff;

    always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
        state_ff <= DET_IDLE;
        cnt_ff   <= 17'h0;
        hits_ff  <= 2'h0;
        probe_ff <= 1'b0;
        term_ff  <= 1'b0;
      end else begin
        probe_ff <= 1'b0;
        if (pd_flt_ff) begin
          state_ff <= DET_IDLE;
          cnt_ff   <= 17'h0;
          hits_ff  <= 2'h0;
          term_ff  <= 1'b0;
        end else if (!det_en && strap_done_ff) begin
          state_ff <= DET_FOUND;
          term_ff  <= 1'b1;
        end else if (start_ch[i]) begin
          state_ff <= DET_PROBE;
          cnt_ff   <= 17'h0;
          hits_ff  <= 2'h0;
          term_ff  <= 1'b0;
        end else begin
          unique case (state_ff)
            DET_IDLE:  term_ff <= 1'b0;
            DET_PROBE: begin
              probe_ff <= 1'b1;
              cnt_ff   <= 17'h0;
              state_ff <= DET_SENSE;
            end
            DET_SENSE: begin
              if (cnt_ff == 17'(SENSE_CYCLES - 1)) begin
                cnt_ff <= 17'h0;
                if (far_s2[i] && hits_ff == need_m1) begin
                  state_ff <= DET_FOUND;
                  term_ff  <= 1'b1;
                end else begin
                  hits_ff  <= far_s2[i] ? hits_ff + 2'h1 : 2'h0;
                  state_ff <= DET_WAIT;
                end
              end else cnt_ff <= cnt_ff + 17'h1;
            end
            DET_WAIT: begin
              if (cnt_ff == 17'(POLL_CYCLES - 1)) begin
                cnt_ff   <= 17'h0;
                state_ff <= DET_PROBE;
              end else cnt_ff <= cnt_ff + 17'h1;
            end
            DET_FOUND: term_ff <= 1'b1;
          endcase
        end
      end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) out_ff <= `CFG_RESET;
      else out_ff <= reg_mode_ff ? ch_cfg_ff[i] : strap_cfg;
    end

    assign first_stage_boost_code_o[4*i +: 4]  = out_ff[`CFG_S1_LSB +: 4];
    assign second_stage_boost_code_o[3*i +: 3] = out_ff[`CFG_S2_LSB +: 3];
    assign midband_shape_code_o[4*i +: 4]      = out_ff[`CFG_PROF_LSB +: 4];
    assign first_stage_skip_o[i]               = out_ff[`CFG_SKIP_BIT];
    assign flat_gain_code_o[3*i +: 3]          = out_ff[`CFG_FLAT_LSB +: 3];
    assign probe_o[i]                          = probe_ff;
    assign term_50_o[i]                        = term_ff;
  end

  // ----------------------------------------
  // secondary addresses and mode outputs
  // ----------------------------------------
  logic [6:0] bank0_ff, bank1_ff;
  logic [6:0] base;

  assign base = (addr_ff == `LVL_FLOAT) ? `ADDR_NONE :
                (mode_ff == `LVL_1) ? `ADDR_BASE_L1 :
                (mode_ff == `LVL_2) ? `ADDR_BASE_L2 : `ADDR_NONE;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bank0_ff <= `ADDR_NONE;
      bank1_ff <= `ADDR_NONE;
    end else if (base == `ADDR_NONE) begin
      bank0_ff <= `ADDR_NONE;
      bank1_ff <= `ADDR_NONE;
    end else begin
      bank0_ff <= 7'(base + {addr_ff, 1'b0});
      bank1_ff <= 7'(base + {addr_ff, 1'b1});
    end
  end

  assign bank0_addr_o = bank0_ff;
  assign bank1_addr_o = bank1_ff;
  assign standby_o    = pd_flt_ff;
  assign reg_mode_o   = reg_mode_ff;

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic       awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic       aw_held_ff, w_held_ff, wr_go, wr_hit;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0]  w_strb_ff;
  logic [1:0]  bresp_ff, rresp_ff;

  assign wr_go  = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit = (aw_addr_ff[7:4] == 4'h1) || (aw_addr_ff == `REG_DET_TRIG);

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 8'h0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `AXI_OKAY;
    end else begin
      awready_ff <= !aw_held_ff && !(s_axi_awvalid && awready_ff) && !bvalid_ff;
      wready_ff  <= !w_held_ff && !(s_axi_wvalid && wready_ff) && !bvalid_ff;
      if (s_axi_awvalid && awready_ff) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end else if (wr_go) aw_held_ff <= 1'b0;
      if (s_axi_wvalid && wready_ff) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_go) w_held_ff <= 1'b0;
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bready) bvalid_ff <= 1'b0;
    end
  end

  // channel words take byte lanes 0 and 1; detect pulses only in register mode
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) ch_cfg_ff[k] <= `CFG_RESET;
      trig_reg_ff <= 4'h0;
    end else begin
      trig_reg_ff <= 4'h0;
      if (wr_go && aw_addr_ff[7:4] == 4'h1) begin
        if (w_strb_ff[0]) ch_cfg_ff[aw_addr_ff[3:2]][7:0] <= w_data_ff[7:0];
        if (w_strb_ff[1]) ch_cfg_ff[aw_addr_ff[3:2]][14:8] <= w_data_ff[14:8];
      end
      if (wr_go && aw_addr_ff == `REG_DET_TRIG && w_strb_ff[0] && reg_mode_ff)
        trig_reg_ff <= w_data_ff[3:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= `AXI_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= `AXI_OKAY;
      rdata_ff   <= 32'h0;
      if (s_axi_araddr[7:4] == 4'h1)
        rdata_ff <= {17'h0, ch_cfg_ff[s_axi_araddr[3:2]]};
      else if ({s_axi_araddr[7:2], 2'h0} == `REG_STATUS)
        rdata_ff <= {15'h0, mode_ff, rxdet_ff, eq_idx, pd_flt_ff, reg_mode_ff, term_50_o};
      else if ({s_axi_araddr[7:2], 2'h0} == `REG_BANK_ADDR)
        rdata_ff <= {17'h0, bank1_ff, 1'b0, bank0_ff};
      else if ({s_axi_araddr[7:2], 2'h0} != `REG_DET_TRIG)
        rresp_ff <= `AXI_SLVERR;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else arready_ff <= 1'b1;
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  standby_hiz_a: assert property (pd_flt_ff |=> term_50_o == 4'h0 && probe_o == 4'h0)
    else $error("power-down did not force standby");
  strap_hold_a: assert property (strap_done_ff |=> $stable(gain_ff) && $stable(hi_ff))
    else $error("strap changed after capture");
  idx_range_a: assert property (eq_idx <= 5'h13)
    else $error("equalizer index above nineteen");
  skip_low_a: assert property (strap_done_ff && !reg_mode_ff && eq_idx < 5'h5 |=>
      first_stage_skip_o == 4'hf)
    else $error("skip missing at low index");
  idx_top_a: assert property (!reg_mode_ff && eq_idx == 5'h13 |=>
      first_stage_boost_code_o[3:0] == 4'hf && second_stage_boost_code_o[2:0] == 3'h7 &&
      midband_shape_code_o[3:0] == 4'hf)
    else $error("top index codes wrong");
  flat_float_a: assert property (!reg_mode_ff && gain_ff == `LVL_FLOAT |=>
      flat_gain_code_o == 12'hb6d)
    else $error("float gain code wrong");
  buffer_mode_a: assert property ((!pd_flt_ff && !det_en && strap_done_ff) [*3] |->
      term_50_o == 4'hf)
    else $error("buffer mode not terminated");
  three_hits_a: assert property ($rose(term_50_o[0]) && det_en && rxdet_ff == `LVL_1 |->
      $past(g_ch[0].hits_ff) == 2'h2)
    else $error("found before three detections");
  two_hits_a: assert property ($rose(term_50_o[0]) && det_en && rxdet_ff == `LVL_2 |->
      $past(g_ch[0].hits_ff) == 2'h1)
    else $error("found before two detections");
  restart_a: assert property (start_ch[0] && !pd_flt_ff && det_en |=>
      g_ch[0].state_ff == DET_PROBE ##1 probe_o[0])
    else $error("trigger did not restart detect");
  addr_l1_a: assert property (mode_ff == `LVL_1 && addr_ff == `LVL_0 |=>
      bank0_addr_o == 7'h18 && bank1_addr_o == 7'h19)
    else $error("secondary address wrong");

  found_c: cover property ($rose(term_50_o[0]) && det_en);
  reg_trig_c: cover property (trig_reg_ff != 4'h0);
  pd_event_c: cover property (pd_fall_ff ##[1:20] probe_o[0]);
  reg_mode_c: cover property ($rose(reg_mode_ff));
endmodule

/* File: redriver_far_end.sv */
// far-end termination model answering the block's probe pulses
`timescale 1ns/1ps
module redriver_far_end (
  input  wire logic       mclk_i,
  input  wire logic [3:0] probe_i,
  input  wire logic [3:0] attached_i,
  output logic      [3:0] present_o
);
  logic [4:0] age [4] = '{default: 5'h1f};
  // the comparator answer is only valid shortly after a probe;
  // outside that window the line shows the inverse, so an unattached channel reads as a stale hit
  always @(posedge mclk_i) begin
    for (int c = 0; c < 4; c++) begin
      if (probe_i[c]) begin
        age[c] <= 5'h0;
      end else if (age[c] != 5'h1f) begin
        age[c] <= age[c] + 5'h1;
      end
    end
  end
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      present_o[c] = (age[c] < 5'h10) ? attached_i[c] : ~attached_i[c];
    end
  end
endmodule

/* File: tb_redriver_config_rx_detect.sv */
// self-checking bench for the redriver configuration and detect block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_redriver_config_rx_detect;
  import redriver_cfg_pkg::*;
  logic mclk_i = 1'b0, nrst_i = 1'b0, powerdown_pin_i = 1'b0, select_pin_i = 1'b0;
  lvl_t boost_select_high_pin_i = 3'h3, boost_select_low_pin_i = 3'h4, gain_pin_i = 3'h0;
  lvl_t mode_pin_i = 3'h1, rxdet_pin_i = 3'h2, addr_pin_i = 3'h3;
  logic [3:0] far_end_present_i, attached = 4'hf, s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, standby_o, reg_mode_o;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] first_stage_boost_code_o, midband_shape_code_o;
  logic [11:0] second_stage_boost_code_o, flat_gain_code_o;
  logic [3:0] first_stage_skip_o, probe_o, term_50_o;
  logic [6:0] bank0_addr_o, bank1_addr_o;
  logic [2:0] gcode [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h5};
  int bad_count = 0, n_checks = 0;
  redriver_config_rx_detect #(.POLL_CYCLES(20), .HOLD_CYCLES(8)) dut (
    .mclk_i, .nrst_i, .boost_select_high_pin_i, .boost_select_low_pin_i, .gain_pin_i,
    .mode_pin_i, .rxdet_pin_i, .addr_pin_i, .powerdown_pin_i, .select_pin_i,
    .far_end_present_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_stage_boost_code_o, .second_stage_boost_code_o,
    .midband_shape_code_o, .first_stage_skip_o, .flat_gain_code_o, .probe_o, .term_50_o,
    .standby_o, .reg_mode_o, .bank0_addr_o, .bank1_addr_o);
  redriver_far_end far (.mclk_i, .probe_i(probe_o), .attached_i(attached),
    .present_o(far_end_present_i));
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // handshakes are judged at the falling edge, where registered outputs are settled
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    kb = 1'b0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!kb) begin
      @(negedge mclk_i);
      ka = s_axi_awvalid & s_axi_awready;
      kw = s_axi_wvalid & s_axi_wready;
      kb = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge mclk_i);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ka, kr;
    kr = 1'b0;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!kr) begin
      @(negedge mclk_i);
      ka = s_axi_arvalid & s_axi_arready;
      kr = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge mclk_i);
      if (ka) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic power_up();
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (40) @(posedge mclk_i);
  endtask
  task automatic wait_term(input logic [3:0] e);
    for (int t = 0; t < 400 && term_50_o !== e; t++) @(negedge mclk_i);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      gain_pin_i <= lvl_t'(i);
      power_up();
      `CHK("flat gain", {4{gcode[i]}}, flat_gain_code_o)
    end
    `CHK("stage one", 16'hffff, first_stage_boost_code_o)
    `CHK("stage two", 12'hfff, second_stage_boost_code_o)
    `CHK("shape", 16'hffff, midband_shape_code_o)
    `CHK("skip", 4'h0, first_stage_skip_o)
    `CHK("bank0", 7'h1e, bank0_addr_o)
    `CHK("bank1", 7'h1f, bank1_addr_o)
    wait_term(4'hf);
    `CHK("detected", 4'hf, term_50_o)
    gain_pin_i <= 3'h1;
    boost_select_high_pin_i <= 3'h0;
    repeat (20) @(posedge mclk_i);
    `CHK("gain held", 12'hb6d, flat_gain_code_o)
    `CHK("boost held", 16'hffff, first_stage_boost_code_o)
    powerdown_pin_i <= 1'b1;
    attached <= 4'hb;
    repeat (16) @(posedge mclk_i);
    `CHK("standby", 1'b1, standby_o)
    `CHK("hi-z", 4'h0, term_50_o)
    powerdown_pin_i <= 1'b0;
    wait_term(4'hb);
    `CHK("redetect", 4'hb, term_50_o)
    mode_pin_i <= 3'h2;
    repeat (10) @(posedge mclk_i);
    `CHK("reg mode", 1'b1, reg_mode_o)
    `CHK("bank0 reg", 7'h26, bank0_addr_o)
    axi_wr(8'h14, 32'h1a5f);
    `CHK("wr resp", 2'h0, resp)
    repeat (2) @(posedge mclk_i);
    `CHK("ch stage one", 16'h00f0, first_stage_boost_code_o)
    `CHK("ch shape", 16'h0040, midband_shape_code_o)
    `CHK("ch skip", 4'h2, first_stage_skip_o)
    `CHK("ch gain", 12'hb4d, flat_gain_code_o)
    axi_rd(8'h14);
    `CHK("readback", 32'h1a5f, rd)
    axi_rd(8'h40);
    `CHK("unmapped", 2'h2, resp)
    attached <= 4'hf;
    wait_term(4'hf);
    `CHK("polled in", 4'hf, term_50_o)
    fork
      axi_wr(8'h04, 32'h1);
      for (int t = 0; t < 50 && probe_o === 4'h0; t++) @(negedge mclk_i);
    join
    `CHK("probe mask", 4'h1, probe_o)
    `CHK("only ch0", 4'he, term_50_o)
    wait_term(4'hf);
    `CHK("ch redetect", 4'hf, term_50_o)
    attached <= 4'h0;
    rxdet_pin_i <= 3'h0;
    mode_pin_i <= 3'h1;
    power_up();
    `CHK("buffer", 4'hf, term_50_o)
    `CHK("low stage one", 16'h7777, first_stage_boost_code_o)
    `CHK("low stage two", 12'h249, second_stage_boost_code_o)
    `CHK("low skip", 4'hf, first_stage_skip_o)
    test_done();
  end
endmodule
